/* File: core/cdrc_map.svh */
// Purpose: Constants for the core and debug reset control block.
// Assumes: Included by bare name from the design files.
// Notes:   Byte offsets on a 4-bit register port; 32-bit data.
//
// Behaviour
// - Core reset is active low, asserts anytime, releases aligned to core clock.
// - Every core flip-flop clears asynchronously the moment core reset asserts.
// - Core reset clears everything except the debug module, which keeps state.
// - Debug reset clears the debug module and the JTAG-side synchronisers.
// - Debug module works with debug reset released while core reset holds.
// - Debugger-started core reset stays internal; nothing signals it to the SoC.
// - Non-debug reset control clears the core but spares debug logic.
// - Dropping non-debug reset with halt request held halts before any fetch.
// - Four bus clock enables: fetch, load/store, debug master, DMA slave.
// - An instance carries one bus type only, AXI4 or AHB-Lite; AXI4 ports are built for either BUS_TYPE.
// - The fetch master issues reads only, never writes.
// - Fetch write channels exist with valid and ready held low.
// - Async inputs pass two flops; senders hold them two core cycles.
`ifndef CDRC_MAP_SVH
`define CDRC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CDRC_OFF_CTRL      4'h0
`define CDRC_OFF_STATUS    4'h4

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CDRC_BIT_ACTIVE    0
`define CDRC_BIT_NDMRESET  1
`define CDRC_BIT_HALTREQ   31
`define CDRC_CTRL_RESET    32'h0000_0000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CDRC_ST_STATE_LSB  0
`define CDRC_ST_HALTED     2
`define CDRC_ST_RUNNING    3
`define CDRC_ST_CLKEN_LSB  4
`define CDRC_ST_TRST       8
`define CDRC_ST_NMI        9
`define CDRC_ST_TIMER      10
`define CDRC_ST_BUS        11

// ----------------------------------------------------------------------
// Fixed fetch read attributes
// ----------------------------------------------------------------------
`define CDRC_AR_LEN        8'h00
`define CDRC_AR_SIZE       3'h3
`define CDRC_AR_BURST      2'h1
`define CDRC_AR_CACHE      4'hF
`define CDRC_AR_PROT       3'h4
`define CDRC_AR_QOS        4'h0
`define CDRC_TIE_LOW       1'h0

`endif

/* File: core/cdrc_pkg.sv */
// Purpose: Types for the core and debug reset control block.
// Assumes: Used by scoped name only.
// Notes:   Constants live in cdrc_map.svh.
package cdrc_pkg;

  // Core sequencing states
  typedef enum logic [1:0] {
    CORE_RESET  = 2'b00,
    CORE_FETCH  = 2'b01,
    CORE_RUN    = 2'b10,
    CORE_HALTED = 2'b11
  } cdrc_core_state_t;

  // System bus flavour of an instance
  typedef enum logic [0:0] {
    BUS_AXI4 = 1'b0,
    BUS_AHB  = 1'b1
  } cdrc_bus_t;

endpackage

/* File: core/cdrc_sync2.sv */
// Purpose: Two-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is held for two clock cycles by its sender.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module cdrc_sync2 #(
  parameter int         WIDTH    = 1,
  parameter logic [0:0] RESET_LV = 1'h0
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_reg;

  // Two stages, reset to the idle level
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_reg <= {WIDTH{RESET_LV}};
      syncOut  <= {WIDTH{RESET_LV}};
    end else begin
      meta_reg <= asyncIn;
      syncOut  <= meta_reg;
    end
  end

endmodule // cdrc_sync2

/* File: core/cdrc_reset_ctrl.sv */
// Purpose: Core and debug reset control with halt-on-reset sequencing.
// Assumes: reset_n is released in step with core_clk by the SoC.
// Notes:   Debug-side state lives on dbgResetN only.
//
// Implementation choices: strobed register access and the placing of the registers.
`include "cdrc_map.svh"
`timescale 1ns/1ps
module cdrc_reset_ctrl #(
  parameter int                 NUM_EXT  = 8,
  parameter cdrc_pkg::cdrc_bus_t BUS_TYPE = cdrc_pkg::BUS_AXI4
) (
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic               dbgResetN,
  // Bus clock enables, synchronous to core_clk
  input  wire logic               ifuBusClkEn,
  input  wire logic               lsuBusClkEn,
  input  wire logic               dbgBusClkEn,
  input  wire logic               dmaBusClkEn,
  // Reset vector, halfword aligned
  input  wire logic [31:1]        rstVec,
  // Asynchronous inputs
  input  wire logic               nmiInt,
  input  wire logic               timerInt,
  input  wire logic [NUM_EXT:1]   extIntReq,
  input  wire logic               jtagTrstN,
  // Register port
  input  wire logic [3:0]         regAddr,
  input  wire logic [31:0]        regWrData,
  input  wire logic               regWrEn,
  input  wire logic               regRdEn,
  output logic      [31:0]        regRdData,
  // Fetch master, write side
  output logic                    fetchAwvalid,
  input  wire logic               fetchAwready,
  output logic                    fetchWvalid,
  input  wire logic               fetchWready,
  input  wire logic               fetchBvalid,
  output logic                    fetchBready,
  // Fetch master, read side
  output logic                    fetchArvalid,
  input  wire logic               fetchArready,
  output logic      [31:0]        fetchAraddr,
  output logic      [7:0]         fetchArlen,
  output logic      [2:0]         fetchArsize,
  output logic      [1:0]         fetchArburst,
  output logic      [3:0]         fetchArcache,
  output logic      [2:0]         fetchArprot,
  output logic      [3:0]         fetchArqos,
  output logic                    fetchRready,
  // Core status
  output logic                    coreHalted,
  output logic                    coreRunning,
  output logic      [NUM_EXT+1:0] irqSync
);

  // ----------------------------------------------------------------------
  // Elaboration constants
  // ----------------------------------------------------------------------

  // Only the AXI4 port set is declared, so an instance always carries exactly
  // one bus type and the other type's ports are simply absent. The flavour is
  // reported in the status word rather than building a second, idle port set.
  // Limitation: an AHB request still builds the AXI4 ports; software must check.
  localparam logic BUS_IS_AHB = (BUS_TYPE == cdrc_pkg::BUS_AHB);

  // Reset image of the control word; each field is picked from it by index
  localparam logic [31:0] CTRL_RESET_VAL = `CDRC_CTRL_RESET;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                       activeReg;
  logic                       ndmResetReg;
  logic                       haltReqReg;
  cdrc_pkg::cdrc_core_state_t state_reg;
  cdrc_pkg::cdrc_core_state_t state_next;
  logic [NUM_EXT+1:0]         irqRaw;
  logic [NUM_EXT+1:0]         irqCore;
  logic                       trstSync;
  logic                       ctrlWrite;
  logic                       statusRead;
  logic                       ctrlRead;
  logic [31:0]                ctrlView;
  logic [31:0]                statusView;
  logic                       fetchAccepted;
  logic                       unusedIn;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // Shared by write and read decode
  function automatic logic addrHit(input logic [3:0] addr,
                                   input logic [3:0] offset);
    addrHit = (addr == offset);
  endfunction

  // Strobes qualified by address
  assign ctrlWrite  = regWrEn && addrHit(regAddr, `CDRC_OFF_CTRL);
  assign ctrlRead   = regRdEn && addrHit(regAddr, `CDRC_OFF_CTRL);
  assign statusRead = regRdEn && addrHit(regAddr, `CDRC_OFF_STATUS);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------

  // Interrupt levels belong to the core, so core reset clears them
  // Both stages reset low, so a level held across reset shows two edges later
  assign irqRaw = {extIntReq, timerInt, nmiInt};

  cdrc_sync2 #(
    .WIDTH    (NUM_EXT + 2),
    .RESET_LV (1'h0)
  ) uIrqSync (
    .clk     (core_clk),
    .rstN    (reset_n),
    .asyncIn (irqRaw),
    .syncOut (irqCore)
  );

  // JTAG-side synchroniser sits with the debug module
  cdrc_sync2 #(
    .WIDTH    (1),
    .RESET_LV (1'h0)
  ) uTrstSync (
    .clk     (core_clk),
    .rstN    (dbgResetN),
    .asyncIn (jtagTrstN),
    .syncOut (trstSync)
  );

  // ----------------------------------------------------------------------
  // Debug module control register
  // ----------------------------------------------------------------------

  // Lives on debug reset only, so a held core reset leaves it usable.
  // A clear of the active bit drops every other control bit with it.
  // Trade-off: one write parks the debug side, at the cost of read-modify-write.
  always_ff @(posedge core_clk or negedge dbgResetN) begin
    if (!dbgResetN) begin
      activeReg   <= CTRL_RESET_VAL[`CDRC_BIT_ACTIVE];
      ndmResetReg <= CTRL_RESET_VAL[`CDRC_BIT_NDMRESET];
      haltReqReg  <= CTRL_RESET_VAL[`CDRC_BIT_HALTREQ];
    end else if (!trstSync) begin
      // JTAG held in reset: nothing may steer the core
      activeReg   <= `CDRC_TIE_LOW;
      ndmResetReg <= `CDRC_TIE_LOW;
      haltReqReg  <= `CDRC_TIE_LOW;
    end else if (ctrlWrite) begin
      activeReg   <= regWrData[`CDRC_BIT_ACTIVE];
      ndmResetReg <= regWrData[`CDRC_BIT_ACTIVE] & regWrData[`CDRC_BIT_NDMRESET];
      haltReqReg  <= regWrData[`CDRC_BIT_ACTIVE] & regWrData[`CDRC_BIT_HALTREQ];
    end
  end

  // ----------------------------------------------------------------------
  // Core sequencing
  // ----------------------------------------------------------------------

  // Next state; the non-debug reset acts as a clear inside the core
  always_comb begin
    state_next = state_reg;
    if (ndmResetReg) begin
      state_next = cdrc_pkg::CORE_RESET;
    end else begin
      case (state_reg)
        cdrc_pkg::CORE_RESET: begin
          // Halt wins over the first fetch after any reset
          if (haltReqReg) begin
            state_next = cdrc_pkg::CORE_HALTED;
          end else begin
            state_next = cdrc_pkg::CORE_FETCH;
          end
        end
        cdrc_pkg::CORE_FETCH: begin
          if (haltReqReg) begin
            state_next = cdrc_pkg::CORE_HALTED;
          end else if (fetchAccepted) begin
            state_next = cdrc_pkg::CORE_RUN;
          end
        end
        cdrc_pkg::CORE_RUN: begin
          if (haltReqReg) begin
            state_next = cdrc_pkg::CORE_HALTED;
          end
        end
        cdrc_pkg::CORE_HALTED: begin
          // Resume goes through the reset-vector fetch once more
          if (!haltReqReg) begin
            state_next = cdrc_pkg::CORE_FETCH;
          end
        end
        default: begin
          state_next = cdrc_pkg::CORE_RESET;
        end
      endcase
    end
  end

  // Core state; no synchroniser on reset_n, the SoC aligns its release
  // Assertion is async and immediate, so no edge is needed to clear the core
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= cdrc_pkg::CORE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address handshake only moves on an enabled bus edge
  assign fetchAccepted = fetchArvalid && fetchArready && ifuBusClkEn;

  // ----------------------------------------------------------------------
  // Fetch master read side
  // ----------------------------------------------------------------------

  // Valid raised on entry to fetch, held until the enabled handshake
  // A halt met mid-fetch leaves valid up, as a raised request may not be withdrawn
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchArvalid <= `CDRC_TIE_LOW;
      fetchAraddr  <= 32'h0000_0000;
    end else if (ndmResetReg) begin
      fetchArvalid <= `CDRC_TIE_LOW;
      fetchAraddr  <= 32'h0000_0000;
    end else if (state_next == cdrc_pkg::CORE_FETCH && !fetchAccepted) begin
      fetchArvalid <= 1'h1;
      fetchAraddr  <= {rstVec, 1'h0};
    end else if (fetchAccepted || state_next != cdrc_pkg::CORE_FETCH) begin
      // Valid may only drop on an enabled edge once raised
      if (!fetchArvalid || fetchAccepted) begin
        fetchArvalid <= `CDRC_TIE_LOW;
      end
    end
  end

  // Read data accepted only while running
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchRready <= `CDRC_TIE_LOW;
    end else begin
      fetchRready <= (state_next == cdrc_pkg::CORE_RUN);
    end
  end

  // Fixed read attributes, held in flops so outputs come from registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchArlen   <= `CDRC_AR_LEN;
      fetchArsize  <= `CDRC_AR_SIZE;
      fetchArburst <= `CDRC_AR_BURST;
      fetchArcache <= `CDRC_AR_CACHE;
      fetchArprot  <= `CDRC_AR_PROT;
      fetchArqos   <= `CDRC_AR_QOS;
    end else begin
      fetchArlen   <= `CDRC_AR_LEN;
      fetchArsize  <= `CDRC_AR_SIZE;
      fetchArburst <= `CDRC_AR_BURST;
      fetchArcache <= `CDRC_AR_CACHE;
      fetchArprot  <= `CDRC_AR_PROT;
      fetchArqos   <= `CDRC_AR_QOS;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch master write side
  // ----------------------------------------------------------------------

  // Reads only: write channels exist but never handshake
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchAwvalid <= `CDRC_TIE_LOW;
      fetchWvalid  <= `CDRC_TIE_LOW;
      fetchBready  <= `CDRC_TIE_LOW;
    end else begin
      fetchAwvalid <= `CDRC_TIE_LOW;
      fetchWvalid  <= `CDRC_TIE_LOW;
      fetchBready  <= `CDRC_TIE_LOW;
    end
  end

  // Write-side inputs are ignored by design
  assign unusedIn = fetchAwready ^ fetchWready ^ fetchBvalid;

  // ----------------------------------------------------------------------
  // Core status outputs
  // ----------------------------------------------------------------------

  // No pin tells the SoC that the debugger reset the core
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      coreHalted  <= `CDRC_TIE_LOW;
      coreRunning <= `CDRC_TIE_LOW;
      irqSync     <= '0;
    end else begin
      coreHalted  <= (state_next == cdrc_pkg::CORE_HALTED);
      coreRunning <= (state_next == cdrc_pkg::CORE_RUN);
      // Interrupts masked while the core sits in its own reset
      irqSync     <= ndmResetReg ? '0 : irqCore;
    end
  end

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------

  // Control word in its documented layout
  always_comb begin
    ctrlView                       = 32'h0000_0000;
    ctrlView[`CDRC_BIT_ACTIVE]     = activeReg;
    ctrlView[`CDRC_BIT_NDMRESET]   = ndmResetReg;
    ctrlView[`CDRC_BIT_HALTREQ]    = haltReqReg;
  end

  // Status word: core state, clock enables and synced levels
  always_comb begin
    statusView                               = 32'h0000_0000;
    statusView[`CDRC_ST_STATE_LSB +: 2]      = state_reg;
    statusView[`CDRC_ST_HALTED]              = (state_reg == cdrc_pkg::CORE_HALTED);
    statusView[`CDRC_ST_RUNNING]             = (state_reg == cdrc_pkg::CORE_RUN);
    statusView[`CDRC_ST_CLKEN_LSB +: 4]      = {dmaBusClkEn, dbgBusClkEn,
                                                lsuBusClkEn, ifuBusClkEn};
    statusView[`CDRC_ST_TRST]                = trstSync;
    statusView[`CDRC_ST_NMI]                 = irqCore[0];
    statusView[`CDRC_ST_TIMER]               = irqCore[1];
    // Lets software see which bus flavour this instance was built with
    statusView[`CDRC_ST_BUS]                 = BUS_IS_AHB;
  end

  // Read data lands one cycle after the strobe; unmapped reads give zero.
  // Held on debug reset so the debugger can read with the core in reset.
  // Status reads see live levels, so two reads in a row may differ.
  always_ff @(posedge core_clk or negedge dbgResetN) begin
    if (!dbgResetN) begin
      regRdData <= 32'h0000_0000;
    end else if (ctrlRead) begin
      regRdData <= ctrlView;
    end else if (statusRead) begin
      regRdData <= statusView;
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule // cdrc_reset_ctrl

/* File: bench/cdrc_soc_model.sv */
// Purpose: SoC-side partner: fetch read-address slave and fetch bus clock enable.
// Assumes: Single core clock; slowMode selects a 1:3 fetch bus ratio.
// Notes:   Ready comes late in slow mode so the core sees a stalled fetch.
`timescale 1ns/1ps
module cdrc_soc_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic slowMode,
  input  wire logic fetchArvalid,
  output logic      ifuBusClkEn,
  output logic      fetchArready
);
  logic [1:0] divReg = 2'h0;
  logic       enReg  = 1'h1;
  logic [1:0] waitReg;

  assign ifuBusClkEn = enReg;

  // Enable every third cycle when slow; the SoC alone picks the ratio
  always @(posedge core_clk) begin
    divReg <= (divReg == 2'h2) ? 2'h0 : divReg + 2'h1;
    enReg  <= !slowMode || (divReg == 2'h2);
  end

  // Ready only after a wait, dropped once the handshake is taken
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitReg      <= 2'h0;
      fetchArready <= 1'h0;
    end else if (fetchArvalid && !(fetchArready && ifuBusClkEn)) begin
      waitReg      <= (waitReg == 2'h3) ? waitReg : waitReg + 2'h1;
      fetchArready <= (waitReg >= (slowMode ? 2'h2 : 2'h0));
    end else begin
      waitReg      <= 2'h0;
      fetchArready <= 1'h0;
    end
  end
endmodule // cdrc_soc_model

/* File: bench/cdrc_reset_ctrl_assertions.sv */
// Purpose: Port-level checks of the reset control block.
// Assumes: Bound into cdrc_reset_ctrl; one clock domain.
// Notes:   Core reset disables every check.
`timescale 1ns/1ps
module cdrc_reset_ctrl_assertions #(
  parameter int NUM_EXT = 8
) (
  input wire logic               core_clk,
  input wire logic               reset_n,
  input wire logic               ifuBusClkEn,
  input wire logic [31:1]        rstVec,
  input wire logic               nmiInt,
  input wire logic               regRdEn,
  input wire logic [31:0]        regRdData,
  input wire logic               fetchAwvalid,
  input wire logic               fetchWvalid,
  input wire logic               fetchBready,
  input wire logic               fetchArvalid,
  input wire logic               fetchArready,
  input wire logic [31:0]        fetchAraddr,
  input wire logic [7:0]         fetchArlen,
  input wire logic [2:0]         fetchArsize,
  input wire logic [1:0]         fetchArburst,
  input wire logic [3:0]         fetchArcache,
  input wire logic [2:0]         fetchArprot,
  input wire logic [3:0]         fetchArqos,
  input wire logic               fetchRready,
  input wire logic               coreHalted,
  input wire logic               coreRunning,
  input wire logic [NUM_EXT+1:0] irqSync
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Fetch port: write side dead, reads fixed in shape
  AST_WR_OFF: assert property (fetchAwvalid == 1'h0 && fetchWvalid == 1'h0 && fetchBready == 1'h0)
    else $error("fetch write channel active");
  AST_RD_SHAPE: assert property (fetchArvalid |-> fetchArlen == 8'h00 && fetchArsize == 3'h3
    && fetchArburst == 2'h1 && fetchArcache == 4'hF && fetchArprot == 3'h4 && fetchArqos == 4'h0)
    else $error("fetch read attributes wrong");
  AST_ADDR_VEC: assert property (fetchArvalid |-> fetchAraddr == {rstVec, 1'h0})
    else $error("first fetch not at reset vector");
  AST_HS_RUN: assert property (fetchArvalid && fetchArready && ifuBusClkEn
    |=> !fetchArvalid && coreRunning && fetchRready) else $error("handshake did not start run");
  // A ready without the bus enable is no handshake
  AST_EN_GATES: assert property (fetchArvalid && !(fetchArready && ifuBusClkEn) |=> !coreRunning)
    else $error("ran without enabled handshake");
  AST_RST_CLEAR: assert property ($rose(reset_n)
    |-> !fetchArvalid && !coreRunning && !coreHalted && irqSync == '0) else $error("reset left state");
  AST_HALT_EXCL: assert property (coreHalted |-> !fetchArvalid && !coreRunning && !fetchRready)
    else $error("halted core still fetching");
  AST_NMI_SYNC: assert property (nmiInt [*3] |=> irqSync[0])
    else $error("held interrupt not seen");
  AST_RD_PULSE: assert property (!regRdEn |=> regRdData == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule // cdrc_reset_ctrl_assertions

bind cdrc_reset_ctrl cdrc_reset_ctrl_assertions #(.NUM_EXT(NUM_EXT)) uChk (
  .core_clk(core_clk), .reset_n(reset_n), .ifuBusClkEn(ifuBusClkEn), .rstVec(rstVec), .nmiInt(nmiInt),
  .regRdEn(regRdEn), .regRdData(regRdData), .fetchAwvalid(fetchAwvalid), .fetchWvalid(fetchWvalid),
  .fetchBready(fetchBready), .fetchArvalid(fetchArvalid), .fetchArready(fetchArready),
  .fetchAraddr(fetchAraddr), .fetchArlen(fetchArlen), .fetchArsize(fetchArsize),
  .fetchArburst(fetchArburst), .fetchArcache(fetchArcache), .fetchArprot(fetchArprot),
  .fetchArqos(fetchArqos), .fetchRready(fetchRready), .coreHalted(coreHalted),
  .coreRunning(coreRunning), .irqSync(irqSync)
);

/* File: bench/cdrc_reset_ctrl_tb.sv */
// Purpose: Self-checking bench for core and debug reset control.
// Assumes: 20 MHz core clock; core reset released on a clock edge.
// Notes:   Read results are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module cdrc_reset_ctrl_tb;
  localparam int NE = 4;
  logic          core_clk  = 1'h0;
  logic          reset_n   = 1'h0;
  logic          dbgResetN = 1'h0;
  logic          jtagTrstN = 1'h1;
  logic          slowMode  = 1'h0;
  logic          lsuEn, dbgEn, dmaEn, ifuBusClkEn, fetchArvalid, fetchArready, fetchRready;
  logic          nmiInt    = 1'h0;
  logic          timerInt  = 1'h0;
  logic [NE:1]   extIntReq = '0;
  logic [31:1]   rstVec;
  logic [3:0]    regAddr   = 4'h0;
  logic [31:0]   regWrData = 32'h0;
  logic          regWrEn   = 1'h0;
  logic          regRdEn   = 1'h0;
  logic          rdSeen    = 1'h0;
  logic          coreHalted, coreRunning;
  logic [31:0]   regRdData, fetchAraddr;
  logic [31:0]   seed      = 32'h0000_0030;
  logic [NE+1:0] irqSync, irqExp;
  logic [31:0]   expQ[$];
  int            nErrors    = 0;
  int            checksDone = 0;

  always #25 core_clk = ~core_clk;

  cdrc_soc_model uSoc (.core_clk(core_clk), .reset_n(reset_n), .slowMode(slowMode),
    .fetchArvalid(fetchArvalid), .ifuBusClkEn(ifuBusClkEn), .fetchArready(fetchArready));

  cdrc_reset_ctrl #(.NUM_EXT(NE)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .dbgResetN(dbgResetN), .ifuBusClkEn(ifuBusClkEn),
    .lsuBusClkEn(lsuEn), .dbgBusClkEn(dbgEn), .dmaBusClkEn(dmaEn), .rstVec(rstVec), .nmiInt(nmiInt),
    .timerInt(timerInt), .extIntReq(extIntReq), .jtagTrstN(jtagTrstN), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .fetchAwvalid(), .fetchAwready(1'h0), .fetchWvalid(), .fetchWready(1'h0), .fetchBvalid(1'h0),
    .fetchBready(), .fetchArvalid(fetchArvalid), .fetchArready(fetchArready), .fetchAraddr(fetchAraddr),
    .fetchArlen(), .fetchArsize(), .fetchArburst(), .fetchArcache(), .fetchArprot(), .fetchArqos(),
    .fetchRready(fetchRready), .coreHalted(coreHalted), .coreRunning(coreRunning), .irqSync(irqSync)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Status word; interrupt bits stay low, fetch enable high in fast mode
  function automatic logic [31:0] st(input logic [1:0] s);
    return {21'h0, 2'h0, jtagTrstN, dmaEn, dbgEn, lsuEn, 1'h1, s == 2'h2, s == 2'h3, s};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'h1;
    @(posedge core_clk);
    regWrEn   <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    expQ.push_back(e);
    @(posedge core_clk);
    regRdEn <= 1'h0;
  endtask

  // Bounded wait for the fetch handshake to start the core
  task automatic waitRun();
    int i;
    for (i = 0; i < 40 && coreRunning !== 1'h1; i++) tick(1);
    check({30'h0, coreRunning, fetchRready}, 32'h3);
    check(fetchAraddr, {rstVec, 1'h0});
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rdSeen) check(regRdData, expQ.pop_front());
    rdSeen <= regRdEn;
  end

  // Hang guard, far beyond the hundred-odd cycles the run needs
  initial begin
    repeat (5000) @(posedge core_clk);
    nErrors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [31:0] seq[4];
    seq = '{32'h0000_0001, 32'h0000_0003, 32'h8000_0003, 32'h8000_0001};
    void'(xs());
    rstVec = seed[31:1];
    {lsuEn, dbgEn, dmaEn} = seed[2:0];
    repeat (10) @(posedge core_clk);
    dbgResetN <= 1'h1;
    tick(3);
    wr(4'h0, 32'h8000_0001);
    rd(4'h0, 32'h8000_0001);
    @(posedge core_clk);
    reset_n <= 1'h1;
    tick(2);
    check({31'h0, coreHalted}, 32'h1);
    wr(4'h0, 32'h0000_0001);
    waitRun();
    rd(4'h4, st(2'h2));
    rd(4'h8, 32'h0);
    wr(4'hC, xs());
    rd(4'h0, 32'h0000_0001);
    foreach (seq[i]) begin
      wr(4'h0, seq[i]);
      tick(1);
      if (i == 1) check({31'h0, coreRunning | coreHalted}, 32'h0);
    end
    check({31'h0, coreHalted}, 32'h1);
    rd(4'h0, 32'h8000_0001);
    rd(4'h4, st(2'h3));
    slowMode <= 1'h1;
    wr(4'h0, 32'h0000_0001);
    waitRun();
    slowMode <= 1'h0;
    #10 reset_n <= 1'h0;
    #1 check({30'h0, coreRunning, fetchArvalid}, 32'h0);
    rd(4'h0, 32'h0000_0001);
    @(posedge core_clk);
    reset_n <= 1'h1;
    waitRun();
    for (i = 0; i < 2; i++) begin
      void'(xs());
      irqExp = seed[NE+1:0];
      // First pass always holds the non-maskable line so its check is reached
      if (i == 0) irqExp[0] = 1'h1;
      @(posedge core_clk);
      {extIntReq, timerInt, nmiInt} <= irqExp;
      tick(3);
      check(32'(irqSync), 32'(irqExp));
      @(posedge core_clk);
      {extIntReq, timerInt, nmiInt} <= '0;
      tick(3);
      check(32'(irqSync), 32'h0);
    end
    @(posedge core_clk);
    jtagTrstN <= 1'h0;
    tick(3);
    rd(4'h0, 32'h0);
    jtagTrstN <= 1'h1;
    tick(3);
    wr(4'h0, 32'h0000_0001);
    @(posedge core_clk);
    dbgResetN <= 1'h0;
    tick(2);
    check({31'h0, coreRunning}, 32'h1);
    dbgResetN <= 1'h1;
    tick(3);
    rd(4'h0, 32'h0);
    tick(3);
    summarize();
  end
endmodule // cdrc_reset_ctrl_tb
